// File: mcp_cfg.svh
// constants of the master clock pll reset control
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH

// ==========================================================
// apb register map (byte addresses)
`define MCP_ADDR_W        12
`define MCP_OFS_CTRL      12'h000
`define MCP_OFS_DIVLO     12'h004
`define MCP_OFS_DIVHI     12'h008
`define MCP_OFS_STAT      12'h00C

// ==========================================================
// field positions
`define MCP_CTRL_FLEX     0
`define MCP_CTRL_FIXT1    1
`define MCP_CTRL_PORT_LO  4
`define MCP_STAT_PLLRST   0
`define MCP_STAT_CSYSRST  1
`define MCP_STAT_IF_LO    2
`define MCP_STAT_SERIAL   4
`define MCP_STAT_N_LO     5
`define MCP_STAT_M_LO     11
`define MCP_STAT_RATE_LO  16

// ==========================================================
// divider widths, fixed-mode values, reset values
`define MCP_N_W           6
`define MCP_M_W           5
`define MCP_STRAP_W       11
`define MCP_PORTS         4
`define MCP_FIXED_N       6'h21
`define MCP_FIXED_M       5'h00
`define MCP_FLEX_RST      1'b1

// ==========================================================
// host interface strap encodings
`define MCP_IM_ASYNC0     2'h0
`define MCP_IM_ASYNC1     2'h1
`define MCP_IM_SPI        2'h2
`define MCP_IM_SCL        2'h3

// ==========================================================
// timing: reference clock period and reset stretch times
`define MCP_CLK_PS        5000
`define MCP_PLL_RST_NS    100
`define MCP_CSYS_RST_NS   50
`define MCP_PLL_RST_CYC   ((`MCP_PLL_RST_NS * 1000 + `MCP_CLK_PS - 1) / `MCP_CLK_PS)
`define MCP_CSYS_RST_CYC  ((`MCP_CSYS_RST_NS * 1000 + `MCP_CLK_PS - 1) / `MCP_CLK_PS)

`endif

// File: mcp_pkg.sv
// types shared by the master clock pll reset control
`include "mcp_cfg.svh"
package mcp_pkg;
  typedef logic [`MCP_N_W-1:0]     mcp_divn_t;
  typedef logic [`MCP_M_W-1:0]     mcp_divm_t;
  typedef logic [`MCP_PORTS-1:0]   mcp_rate_t;
  typedef enum logic [1:0] {
    MCP_HOST_ASYNC0 = `MCP_IM_ASYNC0,
    MCP_HOST_ASYNC1 = `MCP_IM_ASYNC1,
    MCP_HOST_SPI    = `MCP_IM_SPI,
    MCP_HOST_SCL    = `MCP_IM_SCL
  } mcp_host_e;
endpackage : mcp_pkg

// File: mcp_rst_if.sv
// request and stretched reset between control and stretcher
`timescale 1ns/1ps
interface mcp_rst_if;
  logic req;
  logic rstOut;
  modport ctl     (output req, input rstOut);
  modport stretch (input req, output rstOut);
endinterface : mcp_rst_if

// File: mcp_rst_stretch.sv
// reset stretcher: holds its output for LEN cycles after the last request
`timescale 1ns/1ps
module mcp_rst_stretch #(
  parameter int LEN = 20
) (
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  mcp_rst_if.stretch rs
);
  localparam int CW = $clog2(LEN + 1);

  initial begin
    if (LEN < 1) begin
      $error("mcp_rst_stretch: LEN must be at least one");
    end
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          rst_ff;
  wire           cntBusy = (cnt_ff != '0);

  // a held request keeps reloading, so release counts from its end
  assign nxt_cnt = rs.req ? CW'(LEN) : (cntBusy ? cnt_ff - 1'b1 : cnt_ff);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= CW'(LEN);
      rst_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      rst_ff <= (nxt_cnt != '0);
    end
  end

  assign rs.rstOut = rst_ff;
endmodule : mcp_rst_stretch

// File: mcp_clock_ctrl.sv
// master clock pll reset control with apb register access
// ==========================================================
`timescale 1ns/1ps
module mcp_clock_ctrl
  import mcp_pkg::*;
#(
  parameter int PLL_RST_CYC  = `MCP_PLL_RST_CYC,
  parameter int CSYS_RST_CYC = `MCP_CSYS_RST_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`MCP_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [1:0]              hostInterfaceStrap,
  input  wire logic [`MCP_STRAP_W-1:0] divStrap,
  output logic                         pllReset,
  output logic                         clkSysReset,
  output mcp_divn_t                    pllDivN,
  output mcp_divm_t                    pllDivM,
  output mcp_rate_t                    portT1,
  output logic                         flexClockEnable
);

  initial begin
    if (PLL_RST_CYC < 1 || CSYS_RST_CYC < 1) begin
      $error("mcp_clock_ctrl: reset stretch counts must be at least one");
    end
  end

  // ==========================================================
  // pin synchronisers and strap sampling
  logic [1:0]              imS1_ff;
  logic [1:0]              imS2_ff;
  logic [`MCP_STRAP_W-1:0] strapS1_ff;
  logic [`MCP_STRAP_W-1:0] strapS2_ff;
  logic [`MCP_STRAP_W-1:0] strapPrev_ff;

  // data pipeline, not reset: reset must be held three edges to fill it
  always_ff @(posedge core_clk) begin
    imS1_ff      <= hostInterfaceStrap;
    imS2_ff      <= imS1_ff;
    strapS1_ff   <= divStrap;
    strapS2_ff   <= strapS1_ff;
    strapPrev_ff <= strapS2_ff;
  end

  mcp_host_e hostMode;
  wire       serialHost = (hostMode == MCP_HOST_SPI) || (hostMode == MCP_HOST_SCL);
  mcp_divn_t strapN;
  mcp_divm_t strapM;
  wire       strapChg   = (strapS2_ff != strapPrev_ff);
  assign hostMode = mcp_host_e'(imS2_ff);
  assign strapN   = strapS2_ff[`MCP_N_W-1:0];
  assign strapM   = strapS2_ff[`MCP_STRAP_W-1:`MCP_N_W];

  // ==========================================================
  // apb slave: pready one cycle after setup, data captured in setup
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        flex_ff;
  logic        fixT1_ff;
  mcp_rate_t   portSel_ff;
  mcp_divn_t   divN_ff;
  mcp_divm_t   divM_ff;
  mcp_divn_t   pllDivN_ff;
  mcp_divm_t   pllDivM_ff;
  mcp_rate_t   portT1_ff;

  wire setupPh  = psel && !penable;
  wire accessOk = psel && penable && pready_ff;
  wire wrEn     = accessOk && pwrite;
  wire selCtrl  = (paddr == `MCP_OFS_CTRL);
  wire selDivLo = (paddr == `MCP_OFS_DIVLO);
  wire selDivHi = (paddr == `MCP_OFS_DIVHI);
  wire selStat  = (paddr == `MCP_OFS_STAT);
  wire mapped   = selCtrl || selDivLo || selDivHi || selStat;
  wire wrCtrl   = wrEn && selCtrl;
  wire wrDivLo  = wrEn && selDivLo;
  wire wrDivHi  = wrEn && selDivHi;

  mcp_divn_t wrN;
  mcp_divm_t wrM;
  assign wrN = pwdata[`MCP_N_W-1:0];
  assign wrM = pwdata[`MCP_M_W-1:0];

  logic [31:0] ctrlRd;
  logic [31:0] divLoRd;
  logic [31:0] divHiRd;
  logic [31:0] statRd;
  logic [31:0] rdMux;
  logic        pllRst;
  logic        csysRst;

  assign ctrlRd  = {24'h000000, portSel_ff, 2'h0, fixT1_ff, flex_ff};
  assign divLoRd = {26'h0000000, divN_ff};
  assign divHiRd = {27'h0000000, divM_ff};
  assign statRd  = {12'h000, portT1_ff, pllDivM_ff, pllDivN_ff, serialHost,
                    imS2_ff, csysRst, pllRst};
  assign rdMux   = selCtrl  ? ctrlRd  :
                   selDivLo ? divLoRd :
                   selDivHi ? divHiRd :
                   selStat  ? statRd  : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= setupPh;
      pslverr_ff <= setupPh && !mapped;
      prdata_ff  <= (setupPh && !pwrite) ? rdMux : prdata_ff;
    end
  end

  // ==========================================================
  // control registers
  wire flexToggle = wrCtrl && (pwdata[`MCP_CTRL_FLEX] != flex_ff);

  // registers keep written values in every host mode; use is gated below
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flex_ff    <= `MCP_FLEX_RST;
      fixT1_ff   <= 1'b0;
      portSel_ff <= '0;
      divN_ff    <= `MCP_FIXED_N;
      divM_ff    <= `MCP_FIXED_M;
    end else begin
      if (wrCtrl) begin
        flex_ff    <= pwdata[`MCP_CTRL_FLEX];
        fixT1_ff   <= pwdata[`MCP_CTRL_FIXT1];
        portSel_ff <= pwdata[`MCP_CTRL_PORT_LO +: `MCP_PORTS];
      end
      if (wrDivLo) begin
        divN_ff <= wrN;
      end
      if (wrDivHi) begin
        divM_ff <= wrM;
      end
    end
  end

  // ==========================================================
  // effective divider and rate selection
  mcp_divn_t effN;
  mcp_divm_t effM;
  mcp_rate_t effRate;
  // one setting serves both rates, so rate never feeds the dividers
  assign effN    = !flex_ff   ? `MCP_FIXED_N :
                   serialHost ? strapN : divN_ff;
  assign effM    = !flex_ff   ? `MCP_FIXED_M :
                   serialHost ? strapM : divM_ff;
  assign effRate = flex_ff ? portSel_ff : {`MCP_PORTS{fixT1_ff}};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pllDivN_ff <= `MCP_FIXED_N;
      pllDivM_ff <= `MCP_FIXED_M;
      portT1_ff  <= '0;
    end else begin
      pllDivN_ff <= effN;
      pllDivM_ff <= effM;
      portT1_ff  <= effRate;
    end
  end

  // ==========================================================
  // pll and clock system reset causes
  wire regsNotFixed  = (divN_ff != `MCP_FIXED_N) || (divM_ff != `MCP_FIXED_M);
  wire strapNotFixed = (strapN != `MCP_FIXED_N) || (strapM != `MCP_FIXED_M);
  wire divWrChg      = (wrDivLo && (wrN != divN_ff)) || (wrDivHi && (wrM != divM_ff));
  wire parDivReq     = !serialHost && flex_ff && divWrChg;
  wire serStrapReq   = serialHost && strapChg;
  // a forbidden serial-mode toggle still resets when the straps differ from the fixed values; hang avoidance is software's
  wire toggleReq     = flexToggle && (serialHost ? strapNotFixed : regsNotFixed);
  wire pllReq        = parDivReq || serStrapReq || toggleReq;
  wire rateChg       = (effRate != portT1_ff);

  mcp_rst_if pllIf ();
  mcp_rst_if csysIf ();

  assign pllIf.req  = pllReq;
  // held while pll reset stands, so clock system leaves reset later
  assign csysIf.req = pllReq || pllRst || rateChg;
  assign pllRst     = pllIf.rstOut;
  assign csysRst    = csysIf.rstOut;

  mcp_rst_stretch #(
    .LEN (PLL_RST_CYC)
  ) u_pll_stretch (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rs       (pllIf)
  );

  mcp_rst_stretch #(
    .LEN (CSYS_RST_CYC)
  ) u_csys_stretch (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rs       (csysIf)
  );

  // ==========================================================
  // outputs
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign pllReset        = pllRst;
  assign clkSysReset     = csysRst;
  assign pllDivN         = pllDivN_ff;
  assign pllDivM         = pllDivM_ff;
  assign portT1          = portT1_ff;
  assign flexClockEnable = flex_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_parDivChange;
    !serialHost && flex_ff && divWrChg;
  endsequence

  sequence s_rstHeld;
    pllReset [*8];
  endsequence

  property p_resetState;
    @(posedge core_clk) disable iff (1'b0)
      !rst_n |=> (flexClockEnable && pllReset && clkSysReset);
  endproperty

  AST_RESET_STATE: assert property (p_resetState)
    else $error("reset did not force flex mode and pll reset");

  AST_DIV_WRITE_RESET: assert property (s_parDivChange |=> s_rstHeld)
    else $error("changing divider write did not hold pll reset");

  AST_FIXED_NO_WRITE_RESET: assert property (
    (!serialHost && !flex_ff && (wrDivLo || wrDivHi) && !flexToggle && !pllReset)
      |=> !pllReset)
    else $error("fixed mode divider write reset the pll");

  AST_SERIAL_WRITE_IGNORED: assert property (
    (serialHost && (wrDivLo || wrDivHi) && !strapChg && !flexToggle && !pllReset)
      |=> !pllReset)
    else $error("serial mode divider write reset the pll");

  AST_RATE_NO_PLL: assert property (
    (rateChg && !pllReq && !pllReset) |=> (clkSysReset && !pllReset))
    else $error("rate change misapplied resets");

  AST_STRAP_RESET: assert property (
    (serialHost && strapS2_ff != strapPrev_ff) |=> pllReset)
    else $error("strap change did not reset pll");

  AST_STRAP_DIVIDERS: assert property (
    (serialHost && flex_ff) |=> (pllDivN == $past(strapN) && pllDivM == $past(strapM)))
    else $error("serial flex dividers not taken from straps");

  AST_FIXED_DIVIDERS: assert property (
    !flex_ff |=> (pllDivN == `MCP_FIXED_N && pllDivM == `MCP_FIXED_M))
    else $error("fixed mode dividers wrong");

  AST_FIXED_SHARED_RATE: assert property (
    !flex_ff |=> (portT1 == {`MCP_PORTS{$past(fixT1_ff)}}))
    else $error("fixed mode ports do not share one rate");

  AST_TOGGLE_FIXED_REGS: assert property (
    (flexToggle && !serialHost && regsNotFixed) |=> pllReset)
    else $error("flex toggle with non-fixed dividers did not reset pll");

  AST_PLL_IMPLIES_CSYS: assert property (pllReset |-> clkSysReset)
    else $error("pll reset without clock system reset");

  AST_RELEASE_ORDER: assert property (
    $fell(clkSysReset) |-> (!pllReset && $past(!pllReset)))
    else $error("clock system left reset before pll");

endmodule : mcp_clock_ctrl

// File: mcp_strap_src.sv
// board strap pins feeding the master clock pll reset control
`timescale 1ns/1ps
module mcp_strap_src (
  input  wire logic        core_clk,
  input  wire logic [1:0]  hostReq,
  input  wire logic [10:0] divReq,
  output logic      [1:0]  hostInterfaceStrap,
  output logic      [10:0] divStrap
);
  // ==========================================================
  // strap levels
  // pins move on the falling edge, half a cycle away from the rising sampling edge
  always @(negedge core_clk) begin
    hostInterfaceStrap <= hostReq;
    divStrap           <= divReq;
  end
endmodule : mcp_strap_src

// File: tb_top.sv
// self-checking bench for the master clock pll reset control
`timescale 1ns/1ps
module tb_top;
  import mcp_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  hostReq  = 2'h0;
  logic [10:0] divReq   = 11'h021;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pllReset;
  logic        clkSysReset;
  logic        flexClockEnable;
  logic [1:0]  hostInterfaceStrap;
  logic [10:0] divStrap;
  mcp_divn_t   pllDivN;
  mcp_divm_t   pllDivM;
  mcp_rate_t   portT1;
  int          failures = 0;
  int          comparisons = 0;
  integer      seed;
  logic [31:0] q;
  logic [31:0] n;
  logic [31:0] m;
  logic        e;

  // ==========================================================
  // clock and instances
  // reference clock from the board, running before reset release
  always #2.5 core_clk = ~core_clk;

  mcp_strap_src u_straps (.core_clk(core_clk), .hostReq(hostReq), .divReq(divReq),
    .hostInterfaceStrap(hostInterfaceStrap), .divStrap(divStrap));

  // stretch kept at 9 so the design's own stretch checks stay meaningful
  mcp_clock_ctrl #(.PLL_RST_CYC(9), .CSYS_RST_CYC(2)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hostInterfaceStrap(hostInterfaceStrap),
    .divStrap(divStrap), .pllReset(pllReset), .clkSysReset(clkSysReset),
    .pllDivN(pllDivN), .pllDivM(pllDivM), .portT1(portT1),
    .flexClockEnable(flexClockEnable));

  // ==========================================================
  // tasks
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      failures++;
      end_of_test();
    end
    @(posedge core_clk);
  endtask : apb

  // records whether each reset was seen high within cyc cycles
  task automatic watch(input int cyc, input logic expP, input logic expC, input string what);
    logic sp;
    logic sc;
    sp = 1'b0;
    sc = 1'b0;
    repeat (cyc) begin
      @(posedge core_clk);
      sp = sp | (pllReset === 1'b1);
      sc = sc | (clkSysReset === 1'b1);
    end
    check({31'h0, sp}, {31'h0, expP}, {what, " pll"});
    check({31'h0, sc}, {31'h0, expC}, {what, " clksys"});
  endtask : watch

  task automatic settle();
    int k;
    k = 0;
    while ((pllReset !== 1'b0 || clkSysReset !== 1'b0) && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 200) begin
      failures++;
      end_of_test();
    end
  endtask : settle

  // ==========================================================
  // scenarios
  initial begin
    seed = 32'h7fecb899;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    check(flexClockEnable, 32'h1, "flex after reset");
    apb(1'b0, `MCP_OFS_DIVLO, 32'h0); check(q, 32'h21, "divlo reset");
    check(pllDivN, 32'h21, "n after reset");
    apb(1'b0, 12'h010, 32'h0); check({31'h0, e}, 32'h1, "unmapped err");
    $display("test reset done");
    n = ($random(seed) & 32'h1F) + 32'h1;
    m = ($random(seed) & 32'h1F) | 32'h1;
    apb(1'b1, `MCP_OFS_DIVLO, n); watch(6, 1'b1, 1'b1, "n change");
    settle(); check(pllDivN, n, "flex n");
    apb(1'b1, `MCP_OFS_DIVLO, n); watch(6, 1'b0, 1'b0, "n same");
    apb(1'b1, `MCP_OFS_DIVHI, m); watch(6, 1'b1, 1'b1, "m change");
    settle(); check(pllDivM, m, "flex m");
    $display("test flexible dividers done");
    apb(1'b1, `MCP_OFS_CTRL, 32'h0); watch(6, 1'b1, 1'b1, "to fixed");
    settle(); check(pllDivN, 32'h21, "fixed n");
    check(pllDivM, 32'h0, "fixed m");
    apb(1'b1, `MCP_OFS_DIVLO, n ^ 32'h1); watch(6, 1'b0, 1'b0, "fixed write");
    apb(1'b1, `MCP_OFS_CTRL, 32'h2); watch(6, 1'b0, 1'b1, "common rate");
    settle(); check(portT1, 32'hF, "common t1");
    apb(1'b1, `MCP_OFS_DIVLO, 32'h21);
    apb(1'b1, `MCP_OFS_DIVHI, 32'h0);
    apb(1'b1, `MCP_OFS_CTRL, 32'h51); watch(6, 1'b0, 1'b1, "to flex");
    settle(); check(portT1, 32'h5, "port rates");
    $display("test mode toggle done");
    for (int h = 2; h < 4; h++) begin
      rst_n   <= 1'b0;
      hostReq <= h[1:0];
      n = ($random(seed) & 32'h1F) + 32'h1;
      m = $random(seed) & 32'h1F;
      divReq  <= {m[4:0], n[5:0]};
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      settle();
      check(pllDivN, n, "strap n");
      check(pllDivM, m, "strap m");
      apb(1'b0, `MCP_OFS_STAT, 32'h0); check((q >> 4) & 32'h1, 32'h1, "serial");
      apb(1'b1, `MCP_OFS_DIVLO, n ^ 32'h2); watch(6, 1'b0, 1'b0, "serial write");
      check(pllDivN, n, "serial n kept");
      divReq <= {m[4:0], n[5:0] ^ 6'h04};
      watch(10, 1'b1, 1'b1, "strap change");
      settle(); check(pllDivN, n ^ 32'h4, "new strap n");
      divReq <= 11'h021;
      watch(10, 1'b1, 1'b1, "fixed straps");
      settle();
      apb(1'b1, `MCP_OFS_CTRL, 32'h0); watch(6, 1'b0, 1'b0, "serial fixed");
      check(pllDivN, 32'h21, "serial fixed n");
      $display("test serial host %0d done", h);
    end
    end_of_test();
  end
endmodule : tb_top
